/* File: css_pkg.sv */
// constants shared by the column sampling sequencer and its hold cells
// assumes a single 100 MHz system clock and synchronous active-high reset
package css_pkg;

    // ==========================================================
    // geometry
    localparam int NUM_COLUMNS = 300;
    localparam int NUM_TRIPLETS = 100;
    localparam int VIDEO_W = 8;
    localparam int STEP_W = 9;
    localparam logic [8:0] SEQ_STEPS = 9'h12c;
    localparam logic [8:0] SIM_STEPS = 9'h064;
    localparam logic [8:0] LAST_COL = 9'h12b;
    localparam logic [8:0] LAST_TRIP = 9'h063;

    // ==========================================================
    // positions inside the synchronised pin vector
    localparam int PIN_PHASE_ONE = 0;
    localparam int PIN_RSTART = 3;
    localparam int PIN_LSTART = 4;
    localparam int PIN_DIR = 5;
    localparam int PIN_MODE = 6;
    localparam int PIN_HOLD = 7;
    localparam int PIN_TEST = 8;
    localparam int PIN_VID1 = 9;
    localparam int PIN_VID2 = 17;
    localparam int PIN_VID3 = 25;
    localparam int PIN_W = 33;

    // ==========================================================
    // register map, byte addresses
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] COUNT_OFS = 4'h8;
    localparam int CTRL_HALT_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DIR_BIT = 1;
    localparam int STATUS_MODE_BIT = 2;
    localparam int STATUS_HOLD_BIT = 3;
    localparam int STATUS_CASC_BIT = 4;
    localparam int STATUS_STEP_LSB = 16;
    localparam logic CTRL_HALT_RESET = 1'b0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        CSS_IDLE,
        CSS_RUN,
        CSS_CASCADE
    } css_state_type;

endpackage

/* File: css_hold_cell.sv */
// one column: two sample-and-hold banks, one tracking while the other drives
// assumes strobe and bank select are already in the mclk domain
module css_hold_cell
    import css_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sample_strobe,
    input wire logic bank_select,
    input wire logic [VIDEO_W-1:0] video,
    output logic [VIDEO_W-1:0] column_value
);

    logic [VIDEO_W-1:0] bank_one_ff;
    logic [VIDEO_W-1:0] bank_two_ff;

    // ==========================================================
    // banks: track while strobed, keep last value after
    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_one_ff <= '0;
            bank_two_ff <= '0;
        end else if (ce && sample_strobe) begin
            if (bank_select) begin
                bank_one_ff <= video;
            end else begin
                bank_two_ff <= video;
            end
        end
    end

    // ==========================================================
    // driver: the bank not sampling feeds the column
    always_ff @(posedge mclk) begin
        if (rst) begin
            column_value <= '0;
        end else if (ce) begin
            column_value <= bank_select ? bank_two_ff : bank_one_ff;
        end
    end

endmodule

/* File: css_column_sampling_sequencer.sv */
// sampling-timing sequencer of a 300-column source driver with cascade start ports
// assumes all pins asynchronous to mclk, shift clocks well below mclk / 4
module css_column_sampling_sequencer
    import css_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic right_start_port_in,
    output logic right_start_port_out,
    output logic right_start_port_oe,
    input wire logic left_start_port_in,
    output logic left_start_port_out,
    output logic left_start_port_oe,
    input wire logic phase_one_shift_clock,
    input wire logic phase_two_shift_clock,
    input wire logic phase_three_shift_clock,
    input wire logic direction_select,
    input wire logic mode_select,
    input wire logic hold_bank_select,
    input wire logic test_mode,
    input wire logic [VIDEO_W-1:0] video_input_first,
    input wire logic [VIDEO_W-1:0] video_input_second,
    input wire logic [VIDEO_W-1:0] video_input_third,
    output logic [NUM_COLUMNS*VIDEO_W-1:0] column_outputs,
    output logic [NUM_COLUMNS-1:0] position_sampling_pulse,
    output logic first_sampling_pulse,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    logic [PIN_W-1:0] pin_vec;
    logic [PIN_W-1:0] sync1_ff;
    logic [PIN_W-1:0] sync2_ff;
    logic [2:0] clk_hist_ff;
    logic [2:0] clk_rise;
    css_state_type state_ff;
    css_state_type nxt_state;
    logic [STEP_W-1:0] step_ff;
    logic [STEP_W-1:0] nxt_step;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    logic run_dir_ff;
    logic nxt_run_dir;
    logic run_mode_ff;
    logic nxt_run_mode;
    logic cascade_ff;
    logic halt_ff;
    logic [15:0] count_ff;
    logic ack_ff;
    logic start_level;
    logic mode_sim;
    logic advance;
    logic [STEP_W-1:0] total_steps;
    logic pulse_load;
    logic [STEP_W-1:0] col_target;
    logic [STEP_W-1:0] trip_target;
    logic [NUM_COLUMNS-1:0] nxt_strobe;
    logic [31:0] status_word;
    logic [31:0] nxt_readdata;

    // ==========================================================
    // pin synchronisers
    // video lanes may skew by a cycle; the bank keeps tracking, so it settles
    assign pin_vec = {video_input_third, video_input_second, video_input_first, test_mode,
                      hold_bank_select, mode_select, direction_select, left_start_port_in,
                      right_start_port_in, phase_three_shift_clock, phase_two_shift_clock,
                      phase_one_shift_clock};

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (ce) begin
            sync1_ff <= pin_vec;
            sync2_ff <= sync1_ff;
        end
    end

    // edge detect works only on the second stage, never the first
    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_hist_ff <= '0;
        end else if (ce) begin
            clk_hist_ff <= sync2_ff[PIN_PHASE_ONE+2:PIN_PHASE_ONE];
        end
    end

    assign clk_rise = sync2_ff[PIN_PHASE_ONE+2:PIN_PHASE_ONE] & ~clk_hist_ff;

    // ==========================================================
    // sequence control
    // halt and test both abort; once both are low, a start level still high at a phase-one rise restarts
    // only a solid high selects simultaneous; the pad pull-down makes open read low
    assign mode_sim = sync2_ff[PIN_MODE] == 1'b1;
    assign start_level = sync2_ff[PIN_DIR] ? sync2_ff[PIN_RSTART]
                                           : sync2_ff[PIN_LSTART];
    assign total_steps = run_mode_ff ? SIM_STEPS : SEQ_STEPS;
    // simultaneous mode ignores clocks two and three, which sit static
    assign advance = run_mode_ff ? clk_rise[0] : clk_rise[phase_ff];
    assign pulse_load = (state_ff == CSS_RUN) && advance && (step_ff != total_steps);

    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_phase = phase_ff;
        nxt_run_dir = run_dir_ff;
        nxt_run_mode = run_mode_ff;
        case (state_ff)
            CSS_IDLE, CSS_CASCADE: begin
                if (clk_rise[0]) begin
                    // test high stands in for a misuse; nothing starts then
                    if (start_level && !halt_ff && !sync2_ff[PIN_TEST]) begin
                        nxt_state = CSS_RUN;
                        nxt_step = '0;
                        nxt_phase = 2'd0;
                        nxt_run_dir = sync2_ff[PIN_DIR];
                        nxt_run_mode = mode_sim;
                    end else begin
                        nxt_state = CSS_IDLE;
                    end
                end
            end
            CSS_RUN: begin
                // start is not looked at here, so a wide pulse cannot restart
                if (halt_ff || sync2_ff[PIN_TEST]) begin
                    nxt_state = CSS_IDLE;
                end else if (advance) begin
                    if (step_ff == total_steps) begin
                        nxt_state = CSS_CASCADE;
                        nxt_phase = 2'd0;
                    end else begin
                        nxt_step = step_ff + 9'h001;
                        if (!run_mode_ff) begin
                            nxt_phase = (phase_ff == 2'd2) ? 2'd0 : phase_ff + 2'd1;
                        end
                    end
                end
            end
            default: begin
                nxt_state = CSS_IDLE;
            end
        endcase
    end

    // direction and mode latched at capture for the pulse walk; start port enables follow the live direction pin
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= CSS_IDLE;
            step_ff <= '0;
            phase_ff <= 2'd0;
            run_dir_ff <= 1'b1;
            run_mode_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            phase_ff <= nxt_phase;
            run_dir_ff <= nxt_run_dir;
            run_mode_ff <= nxt_run_mode;
        end
    end

    // ==========================================================
    // position pulses
    // one compare per column, not a shift chain, so direction costs nothing
    assign col_target = run_dir_ff ? step_ff : LAST_COL - step_ff;
    assign trip_target = run_dir_ff ? step_ff : LAST_TRIP - step_ff;

    always_comb begin
        for (int i = 0; i < NUM_COLUMNS; i++) begin
            if (run_mode_ff) begin
                nxt_strobe[i] = STEP_W'(i / 3) == trip_target;
            end else begin
                nxt_strobe[i] = STEP_W'(i) == col_target;
            end
        end
    end

    // a pulse lasts one step, i.e. until the next advancing edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            position_sampling_pulse <= '0;
            first_sampling_pulse <= 1'b0;
        end else if (ce) begin
            if (pulse_load) begin
                position_sampling_pulse <= nxt_strobe;
                first_sampling_pulse <= step_ff == '0;
            end else if (nxt_state != CSS_RUN) begin
                position_sampling_pulse <= '0;
                first_sampling_pulse <= 1'b0;
            end
        end
    end

    // ==========================================================
    // cascade output
    // both ports carry the level; only the enabled one reaches its pin
    always_ff @(posedge mclk) begin
        if (rst) begin
            cascade_ff <= 1'b0;
        end else if (ce) begin
            cascade_ff <= nxt_state == CSS_CASCADE;
        end
    end

    assign right_start_port_out = cascade_ff;
    assign left_start_port_out = cascade_ff;
    assign right_start_port_oe = ~sync2_ff[PIN_DIR];
    assign left_start_port_oe = sync2_ff[PIN_DIR];

    // ==========================================================
    // hold cells, one per column
    // lane chosen by position in the triplet, independent of direction
    for (genvar c = 0; c < NUM_COLUMNS; c++) begin : g_col
        localparam int VID_LSB = (c % 3 == 0) ? PIN_VID1 : ((c % 3 == 1) ? PIN_VID2 : PIN_VID3);
        css_hold_cell u_cell (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .sample_strobe(position_sampling_pulse[c]),
            .bank_select(sync2_ff[PIN_HOLD]),
            .video(sync2_ff[VID_LSB+VIDEO_W-1:VID_LSB]),
            .column_value(column_outputs[c*VIDEO_W+:VIDEO_W])
        );
    end

    // ==========================================================
    // register slave: one wait state on every access
    // ce low freezes ack: frozen low, waitrequest stays high and the master waits; frozen high, requests pass unwaited
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else if (ce) begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    assign status_word = (32'(step_ff) << STATUS_STEP_LSB)
                       | (32'(cascade_ff) << STATUS_CASC_BIT)
                       | (32'(sync2_ff[PIN_HOLD]) << STATUS_HOLD_BIT)
                       | (32'(run_mode_ff) << STATUS_MODE_BIT)
                       | (32'(run_dir_ff) << STATUS_DIR_BIT)
                       | (32'(state_ff == CSS_RUN) << STATUS_BUSY_BIT);

    always_comb begin
        case (avs_address)
            CTRL_OFS: nxt_readdata = 32'(halt_ff) << CTRL_HALT_BIT;
            STATUS_OFS: nxt_readdata = status_word;
            COUNT_OFS: nxt_readdata = 32'(count_ff);
            default: nxt_readdata = READ_ZERO;
        endcase
    end

    // loaded in the wait cycle so it stands through the answer cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= READ_ZERO;
        end else if (ce && avs_read && !ack_ff) begin
            avs_readdata <= nxt_readdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            halt_ff <= CTRL_HALT_RESET;
        end else if (ce && avs_write && ack_ff && avs_address == CTRL_OFS && avs_byteenable[0]) begin
            halt_ff <= avs_writedata[CTRL_HALT_BIT];
        end
    end

    // counts finished sequences; wraps, no clear
    // an aborted sequence is not counted
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_ff <= COUNT_RESET;
        end else if (ce && state_ff == CSS_RUN && nxt_state == CSS_CASCADE) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

endmodule

/* File: css_column_sampling_sequencer_assertions.sv */
// checker on the sequencer pins: pulse walk, cascade, bus wait state
// assumes ce held high; bound onto every sequencer instance
module css_column_sampling_sequencer_assertions
    import css_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic right_start_port_out,
    input wire logic right_start_port_oe,
    input wire logic left_start_port_oe,
    input wire logic [NUM_COLUMNS-1:0] position_sampling_pulse,
    input wire logic first_sampling_pulse,
    input wire logic [NUM_COLUMNS*VIDEO_W-1:0] column_outputs,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    // ==========================================================
    // properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire [NUM_COLUMNS-1:0] sp = position_sampling_pulse;

    property p_roles;
        right_start_port_oe != left_start_port_oe;
    endproperty
    a_roles: assert property (p_roles) else $error("start ports share a role");
    property p_walk;
        $past(sp) != '0 && sp != '0 && sp != $past(sp) |-> sp == $past(sp) << 1
            || sp == $past(sp) >> 1 || sp == $past(sp) << 3 || sp == $past(sp) >> 3;
    endproperty
    a_walk: assert property (p_walk) else $error("pulse jumped");
    property p_ones;
        $countones(sp) inside {0, 1, 3};
    endproperty
    a_ones: assert property (p_ones) else $error("bad pulse count");
    property p_first;
        first_sampling_pulse |-> sp[0] || sp[NUM_COLUMNS-1];
    endproperty
    a_first: assert property (p_first) else $error("first pulse off end");
    property p_from_zero;
        $past(sp) == '0 && sp != '0 |-> first_sampling_pulse;
    endproperty
    a_from_zero: assert property (p_from_zero) else $error("start without first");
    property p_casc_quiet;
        right_start_port_out |-> sp == '0;
    endproperty
    a_casc_quiet: assert property (p_casc_quiet) else $error("pulse in cascade");
    property p_casc_rise;
        $rose(right_start_port_out) |-> $past(sp[0]) || $past(sp[NUM_COLUMNS-1]);
    endproperty
    a_casc_rise: assert property (p_casc_rise) else $error("early cascade");
    property p_reset;
        disable iff (1'b0) rst |=> sp == '0 && !right_start_port_out && column_outputs == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not cleared");
    // fixed single wait state per request
    property p_bus;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus wait state wrong");
endmodule

bind css_column_sampling_sequencer css_column_sampling_sequencer_assertions CHK (
    .mclk(mclk),
    .rst(rst),
    .right_start_port_out(right_start_port_out),
    .right_start_port_oe(right_start_port_oe),
    .left_start_port_oe(left_start_port_oe),
    .position_sampling_pulse(position_sampling_pulse),
    .first_sampling_pulse(first_sampling_pulse),
    .column_outputs(column_outputs),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest)
);

/* File: css_timing_controller_model.sv */
// timing controller model: three shift clocks and start pulse levels
// assumes the bench resolves each start pin against the device enables
module css_timing_controller_model (
    input wire logic mclk,
    output logic ph1,
    output logic ph2,
    output logic ph3,
    output logic st_r,
    output logic st_l
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ck_ff = 3'h0;
    // ==========================================================
    // clocks stand low between pulses, no free run
    assign ph1 = ck_ff[0];
    assign ph2 = ck_ff[1];
    assign ph3 = ck_ff[2];
    initial begin
        st_r = 1'h0;
        st_l = 1'h0;
    end
    task automatic start(input bit d, input bit lv);
        @(posedge mclk);
        if (d) begin
            st_r <= lv;
        end else begin
            st_l <= lv;
        end
    endtask
    // 4 mclk high, then low until the next call
    task automatic pulse(input int c, input bit sim);
        @(posedge mclk);
        ck_ff <= sim ? 3'h1 : 3'h1 << (c - 1);
        repeat (4) @(posedge mclk);
        ck_ff <= 3'h0;
    endtask
endmodule

/* File: test_column_sampling_sequencer.sv */
// bench: walks, cascade, banks and registers against an array model
// assumes the controller model and the bound checker compile first
module test_column_sampling_sequencer
    import css_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic dir_r = 1'h0, mode_r = 1'h0, float_r = 1'h0, hold_r = 1'h0;
    logic [VIDEO_W-1:0] v1 = '0, v2 = '0, v3 = '0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0, avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    wire rw, lw, ro, roe, lo, loe, p1, p2, p3, sr, sl, fsp, wreq;
    wire [NUM_COLUMNS-1:0] sp;
    wire [NUM_COLUMNS*VIDEO_W-1:0] cols;
    wire [31:0] rdata;
    int err_total = 0, checked = 0, nseq = 0;
    logic [VIDEO_W-1:0] b1 [NUM_COLUMNS] = '{default: '0};
    logic [VIDEO_W-1:0] b2 [NUM_COLUMNS] = '{default: '0};
    logic [15:0] lfs = 16'hdc15;
    // ==========================================================
    // wiring: device enable wins the two-way start pins
    assign rw = roe ? ro : sr;
    assign lw = loe ? lo : sl;
    css_timing_controller_model PTN (.mclk(mclk), .ph1(p1), .ph2(p2), .ph3(p3),
        .st_r(sr), .st_l(sl));
    css_column_sampling_sequencer DUT (.mclk(mclk), .rst(rst), .ce(1'h1),
        .right_start_port_in(rw), .right_start_port_out(ro), .right_start_port_oe(roe),
        .left_start_port_in(lw), .left_start_port_out(lo), .left_start_port_oe(loe),
        .phase_one_shift_clock(p1), .phase_two_shift_clock(p2), .phase_three_shift_clock(p3),
        .direction_select(dir_r), .mode_select(float_r ? 1'h0 : mode_r),
        .hold_bank_select(hold_r), .test_mode(1'h0),
        .video_input_first(v1), .video_input_second(v2), .video_input_third(v3),
        .column_outputs(cols), .position_sampling_pulse(sp), .first_sampling_pulse(fsp),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wreq));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ==========================================================
    // tasks
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string nm, input logic [NUM_COLUMNS*VIDEO_W-1:0] s, e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wreq !== 1'h0 && n < 50);
        if (wreq !== 1'h0) begin
            err_total++;
            end_sim();
        end
        r = rdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic reg_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, '0, r);
        check(nm, r, e);
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic run_seq(input string nm, input bit d, m, fl, h, lng, input int ab);
        logic [NUM_COLUMNS-1:0] e;
        logic [NUM_COLUMNS*VIDEO_W-1:0] ec;
        logic [VIDEO_W-1:0] vv [3];
        logic [31:0] r;
        int n, c, s;
        @(posedge mclk);
        dir_r <= d; // levels move only between sequences
        mode_r <= m;
        float_r <= fl;
        hold_r <= h;
        repeat (8) @(posedge mclk);
        for (int j = 0; j < NUM_COLUMNS; j++) ec[j*VIDEO_W +: VIDEO_W] = h ? b2[j] : b1[j];
        check("columns", cols, ec);
        s = m && !fl;
        n = s ? NUM_TRIPLETS : NUM_COLUMNS;
        PTN.start(d, 1'h1);
        PTN.pulse(1, s);
        if (!lng) PTN.start(d, 1'h0);
        for (int k = 0; k < n; k++) begin
            PTN.pulse(k % 3 + 1, s);
            if (lng && k == 2) PTN.start(d, 1'h0);
            lfs = lf(lfs);
            vv[0] = lfs[7:0];
            vv[1] = lfs[15:8];
            vv[2] = lfs[7:0] ^ lfs[15:8];
            v1 <= vv[0];
            v2 <= vv[1];
            v3 <= vv[2];
            e = '0;
            for (int j = 0; j < (s ? 3 : 1); j++) begin
                c = s ? (d ? 3 * k : NUM_COLUMNS - 3 - 3 * k) + j : (d ? k : NUM_COLUMNS - 1 - k);
                e[c] = 1'h1;
                if (h) b1[c] = vv[c % 3];
                else b2[c] = vv[c % 3];
            end
            settle();
            check("pulse", sp, e);
            check("first", fsp, k == 0);
            if (k == ab) begin
                bus(1'h1, CTRL_OFS, 32'h0000_0001, r);
                reg_chk("halt", CTRL_OFS, 32'h0000_0001);
                bus(1'h0, STATUS_OFS, '0, r);
                check("busy", r[STATUS_BUSY_BIT], 1'h0);
                check("aborted", sp, '0);
                bus(1'h1, CTRL_OFS, 32'h0000_0000, r);
                $display("test %s done", nm);
                return;
            end
        end
        PTN.pulse(1, s);
        settle();
        check("cascade", d ? lw : rw, 1'h1);
        check("out role", d ? loe : roe, 1'h1);
        check("idle", sp, '0);
        PTN.pulse(1, s);
        settle();
        check("cascade end", d ? lw : rw, 1'h0);
        nseq++;
        $display("test %s done", nm);
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        for (int a = 0; a < 16; a += 4) begin
            // status shows the reset shift direction, right
            reg_chk("reset value", 4'(a),
                (4'(a) == STATUS_OFS) ? 32'h0000_0001 << STATUS_DIR_BIT : READ_ZERO);
        end
        bus(1'h1, COUNT_OFS, 32'hffff_ffff, r);
        bus(1'h1, 4'hc, 32'hffff_ffff, r);
        reg_chk("count ro", COUNT_OFS, READ_ZERO);
        reg_chk("unmapped", 4'hc, READ_ZERO);
        $display("test registers done");
        run_seq("right sequential", 1, 0, 0, 1, 0, -1);
        run_seq("left long start", 0, 0, 0, 0, 1, -1);
        run_seq("right simultaneous", 1, 1, 0, 1, 0, -1);
        run_seq("left simultaneous", 0, 1, 0, 0, 0, -1);
        run_seq("mode floating", 1, 1, 1, 1, 0, -1);
        reg_chk("count", COUNT_OFS, 32'(nseq));
        run_seq("halt abort", 0, 0, 0, 0, 0, 5);
        run_seq("final banks", 1, 0, 0, 1, 0, 0);
        end_sim();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        end_sim();
    end
endmodule
